/* src/mmac_pkg.sv */
package mmac_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [31:0] MEAS_MODE_IDX = 32'h0000_e700;
  localparam logic [31:0] ACC_MODE_IDX = 32'h0000_e701;
  localparam logic [31:0] EVENT_IDX = 32'h0000_e710;
  localparam logic [31:0] EVENT_MASK_IDX = 32'h0000_e711;
  localparam logic [31:0] PEAK_IDX = 32'h0000_e712;
  localparam logic [31:0] MEAS_MODE_ADDR = MEAS_MODE_IDX << 2;
  localparam logic [31:0] ACC_MODE_ADDR = ACC_MODE_IDX << 2;
  localparam logic [31:0] EVENT_ADDR = EVENT_IDX << 2;
  localparam logic [31:0] EVENT_MASK_ADDR = EVENT_MASK_IDX << 2;
  localparam logic [31:0] PEAK_ADDR = PEAK_IDX << 2;

  // Measurement mode fields.
  localparam int ACT_SRC_BIT = 0;
  localparam int REACT_SRC_BIT = 1;
  localparam int PEAK_INC_LSB = 2;
  localparam logic [7:0] MEAS_MODE_RESET = 8'h1c;
  localparam logic [7:0] MEAS_MODE_USED = 8'h1f;

  // Accumulation mode fields.
  localparam int ACT_ACC_LSB = 0;
  localparam int REACT_ACC_LSB = 2;
  localparam logic [7:0] ACC_MODE_RESET = 8'h00;
  localparam logic [7:0] ACC_MODE_USED = 8'h0f;
  localparam logic [1:0] ACC_CODE_00 = 2'h0;
  localparam logic [1:0] ACC_CODE_01 = 2'h1;
  localparam logic [1:0] ACC_CODE_10 = 2'h2;
  localparam logic [1:0] ACC_CODE_11 = 2'h3;

  // Event word layout.
  localparam int ACT_REV_LSB = 6;
  localparam int REACT_REV_LSB = 10;
  localparam logic [31:0] EVENT_USED = 32'h0000_1dc0;
  localparam logic [31:0] EVENT_RESET = 32'h0000_0000;

  // Bus answers.
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [3:0] {
    MMAC_SIGNED = 4'h1,
    MMAC_POS_ONLY = 4'h2,
    MMAC_ABS = 4'h4,
    MMAC_FOLLOW = 4'h8
  } mmac_cond_t;

endpackage

/* src/mmac_term_if.sv */
interface mmac_term_if #(
  parameter int PW = 24
);
  logic signed [PW-1:0] power;
  logic ref_neg;
  mmac_pkg::mmac_cond_t energy_mode;
  mmac_pkg::mmac_cond_t pulse_mode;
  logic signed [PW:0] energy_term;
  logic signed [PW:0] pulse_term;

  modport ctrl (
    output power,
    output ref_neg,
    output energy_mode,
    output pulse_mode,
    input energy_term,
    input pulse_term
  );

  modport cond (
    input power,
    input ref_neg,
    input energy_mode,
    input pulse_mode,
    output energy_term,
    output pulse_term
  );
endinterface

/* src/mmac_term_cond.sv */
module mmac_term_cond #(
  parameter int PW = 24
) (
  // Power term and its conditioning modes.
  mmac_term_if.cond t
);

  function automatic logic signed [PW:0] apply(
    input mmac_pkg::mmac_cond_t mode,
    input logic signed [PW-1:0] value,
    input logic ref_neg
  );
    logic signed [PW:0] wide;
    wide = {value[PW-1], value};
    case (mode)
      mmac_pkg::MMAC_SIGNED: apply = wide;
      mmac_pkg::MMAC_POS_ONLY: apply = value[PW-1] ? '0 : wide;
      mmac_pkg::MMAC_ABS: apply = value[PW-1] ? -wide : wide;
      mmac_pkg::MMAC_FOLLOW: apply = ref_neg ? -wide : wide;
      default: apply = wide;
    endcase
  endfunction

  // Widened by one bit so that negating the most negative sample cannot wrap.
  assign t.energy_term = apply(t.energy_mode, t.power, t.ref_neg);
  assign t.pulse_term = apply(t.pulse_mode, t.power, t.ref_neg);

endmodule // mmac_term_cond

/* src/mmac_config.sv */
// What this block does
// - Active reverse flags follow total or fundamental power.
// - Reactive reverse flags follow total or fundamental power.
// - Per-phase include bits gate peak detection.
// - Mode bits seven to five do nothing.
// - Active code 00: signed energy and pulses.
// - Active code 01: positive energy, signed pulses.
// - Active code 10 behaves as code 00.
// - Active code 11: absolute energy and pulses.
// - Reactive code 00: signed energy and pulses.
// - Reactive code 01 behaves as code 00.
// - Reactive code 10: sign follows active power.
// - Reactive code 11: absolute energy and pulses.
module mmac_config #(
  parameter int PW = 24,
  parameter int AW = 20
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // AXI4-Lite write channels.
  input wire logic [AW-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read channels.
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Per-phase power, voltage and current samples from the datapath.
  input wire logic sample_valid,
  input wire logic [2:0][PW-1:0] active_total,
  input wire logic [2:0][PW-1:0] active_fund,
  input wire logic [2:0][PW-1:0] reactive_total,
  input wire logic [2:0][PW-1:0] reactive_fund,
  input wire logic [2:0][PW-1:0] volt_sample,
  input wire logic [2:0][PW-1:0] curr_sample,
  // Conditioned terms: index 0 total active, 1 fundamental active,
  // 2 total reactive, 3 fundamental reactive.
  output logic term_valid,
  output logic [3:0][2:0][PW:0] energy_term,
  output logic [3:0][2:0][PW:0] pulse_freq_outputs,
  // Peak detection of the included phases.
  output logic [PW-1:0] volt_peak,
  output logic [PW-1:0] curr_peak,
  output logic [2:0] volt_peak_phase,
  output logic [2:0] curr_peak_phase,
  // Interrupt.
  output logic irq
);

  logic [7:0] measurement_mode_config;
  logic [7:0] accumulation_mode_config;
  logic [31:0] event_word_zero;
  logic [31:0] event_mask;

  logic aw_held;
  logic [AW-1:0] aw_addr;
  logic w_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic wr_fire;
  logic ar_fire;
  logic wr_hit;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;

  logic active_reverse_source_sel;
  logic reactive_reverse_source_sel;
  logic [2:0] peak_phase_include;
  logic [1:0] active_accum_mode;
  logic [1:0] reactive_accum_mode;
  mmac_pkg::mmac_cond_t act_energy_mode;
  mmac_pkg::mmac_cond_t act_pulse_mode;
  mmac_pkg::mmac_cond_t react_mode;

  logic [3:0][2:0][PW:0] next_energy;
  logic [3:0][2:0][PW:0] next_pulse;
  logic [2:0] act_rev;
  logic [2:0] react_rev;
  logic [31:0] event_set;
  logic [31:0] event_clr;
  logic [PW-1:0] next_volt_peak;
  logic [PW-1:0] next_curr_peak;
  logic [2:0] next_volt_phase;
  logic [2:0] next_curr_phase;

  // Field extraction; bits 7 to 5 feed nothing.
  assign active_reverse_source_sel = measurement_mode_config[mmac_pkg::ACT_SRC_BIT];
  assign reactive_reverse_source_sel = measurement_mode_config[mmac_pkg::REACT_SRC_BIT];
  assign peak_phase_include = measurement_mode_config[mmac_pkg::PEAK_INC_LSB +: 3];
  assign active_accum_mode = accumulation_mode_config[mmac_pkg::ACT_ACC_LSB +: 2];
  assign reactive_accum_mode = accumulation_mode_config[mmac_pkg::REACT_ACC_LSB +: 2];

  // Bus handshakes; nothing is accepted while the clock enable is low.
  assign s_axi_awready = clk_en && !aw_held && !s_axi_bvalid;
  assign s_axi_wready = clk_en && !w_held && !s_axi_bvalid;
  assign s_axi_arready = clk_en && !s_axi_rvalid;
  assign wr_fire = clk_en && aw_held && w_held && !s_axi_bvalid;
  assign ar_fire = s_axi_arvalid && s_axi_arready;

  always_comb
  begin
    wr_hit = 1'b0;
    if ((32'(aw_addr) == mmac_pkg::MEAS_MODE_ADDR) || (32'(aw_addr) == mmac_pkg::ACC_MODE_ADDR)
        || (32'(aw_addr) == mmac_pkg::EVENT_ADDR) || (32'(aw_addr) == mmac_pkg::EVENT_MASK_ADDR)
        || (32'(aw_addr) == mmac_pkg::PEAK_ADDR))
    begin
      wr_hit = 1'b1;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      aw_held <= 1'b0;
      aw_addr <= '0;
    end
    else if (clk_en)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      else if (wr_fire)
      begin
        aw_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      w_held <= 1'b0;
      w_data <= '0;
      w_strb <= '0;
    end
    else if (clk_en)
    begin
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      else if (wr_fire)
      begin
        w_held <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= mmac_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? mmac_pkg::RESP_OKAY : mmac_pkg::RESP_SLVERR;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // Configuration writes; unimplemented positions are never stored.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      measurement_mode_config <= mmac_pkg::MEAS_MODE_RESET;
      accumulation_mode_config <= mmac_pkg::ACC_MODE_RESET;
      event_mask <= mmac_pkg::EVENT_RESET;
    end
    else if (wr_fire)
    begin
      if (w_strb[0] && (32'(aw_addr) == mmac_pkg::MEAS_MODE_ADDR))
      begin
        measurement_mode_config <= w_data[7:0] & mmac_pkg::MEAS_MODE_USED;
      end
      if (w_strb[0] && (32'(aw_addr) == mmac_pkg::ACC_MODE_ADDR))
      begin
        accumulation_mode_config <= w_data[7:0] & mmac_pkg::ACC_MODE_USED;
      end
      if (32'(aw_addr) == mmac_pkg::EVENT_MASK_ADDR)
      begin
        for (int b = 0; b < 4; b++)
        begin
          if (w_strb[b])
          begin
            event_mask[b*8 +: 8] <= w_data[b*8 +: 8] & mmac_pkg::EVENT_USED[b*8 +: 8];
          end
        end
      end
    end
  end

  // Read path.
  always_comb
  begin
    next_rdata = '0;
    next_rresp = mmac_pkg::RESP_OKAY;
    case (32'(s_axi_araddr))
      mmac_pkg::MEAS_MODE_ADDR: next_rdata = {24'h00_0000, measurement_mode_config};
      mmac_pkg::ACC_MODE_ADDR: next_rdata = {24'h00_0000, accumulation_mode_config};
      mmac_pkg::EVENT_ADDR: next_rdata = event_word_zero;
      mmac_pkg::EVENT_MASK_ADDR: next_rdata = event_mask;
      mmac_pkg::PEAK_ADDR:
      begin
        next_rdata[5:0] = {curr_peak_phase, volt_peak_phase};
      end
      default: next_rresp = mmac_pkg::RESP_SLVERR;
    endcase
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= '0;
      s_axi_rresp <= mmac_pkg::RESP_OKAY;
    end
    else if (clk_en)
    begin
      if (ar_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= next_rdata;
        s_axi_rresp <= next_rresp;
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Mode decode into conditioning choices for energy and pulse paths.
  always_comb
  begin
    act_energy_mode = mmac_pkg::MMAC_SIGNED;
    act_pulse_mode = mmac_pkg::MMAC_SIGNED;
    case (active_accum_mode)
      mmac_pkg::ACC_CODE_00: act_energy_mode = mmac_pkg::MMAC_SIGNED;
      mmac_pkg::ACC_CODE_01: act_energy_mode = mmac_pkg::MMAC_POS_ONLY;
      mmac_pkg::ACC_CODE_10: act_energy_mode = mmac_pkg::MMAC_SIGNED;
      mmac_pkg::ACC_CODE_11:
      begin
        act_energy_mode = mmac_pkg::MMAC_ABS;
        act_pulse_mode = mmac_pkg::MMAC_ABS;
      end
      default: act_energy_mode = mmac_pkg::MMAC_SIGNED;
    endcase
  end

  always_comb
  begin
    case (reactive_accum_mode)
      mmac_pkg::ACC_CODE_00: react_mode = mmac_pkg::MMAC_SIGNED;
      mmac_pkg::ACC_CODE_01: react_mode = mmac_pkg::MMAC_SIGNED;
      mmac_pkg::ACC_CODE_10: react_mode = mmac_pkg::MMAC_FOLLOW;
      mmac_pkg::ACC_CODE_11: react_mode = mmac_pkg::MMAC_ABS;
      default: react_mode = mmac_pkg::MMAC_SIGNED;
    endcase
  end

  // One conditioner per phase and per power kind.
  for (genvar p = 0; p < 3; p++)
  begin : g_phase
    for (genvar k = 0; k < 4; k++)
    begin : g_kind
      mmac_term_if #(.PW(PW)) t ();
      mmac_term_cond #(.PW(PW)) u_cond (.t(t));

      if (k == 0)
      begin : g_act_tot
        assign t.power = active_total[p];
        assign t.ref_neg = 1'b0;
      end
      else if (k == 1)
      begin : g_act_fund
        assign t.power = active_fund[p];
        assign t.ref_neg = 1'b0;
      end
      else if (k == 2)
      begin : g_react_tot
        assign t.power = reactive_total[p];
        assign t.ref_neg = active_total[p][PW-1];
      end
      else
      begin : g_react_fund
        assign t.power = reactive_fund[p];
        assign t.ref_neg = active_fund[p][PW-1];
      end
      assign t.energy_mode = (k < 2) ? act_energy_mode : react_mode;
      assign t.pulse_mode = (k < 2) ? act_pulse_mode : react_mode;
      assign next_energy[k][p] = t.energy_term;
      assign next_pulse[k][p] = t.pulse_term;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      term_valid <= 1'b0;
      energy_term <= '0;
      pulse_freq_outputs <= '0;
    end
    else if (clk_en)
    begin
      term_valid <= sample_valid;
      if (sample_valid)
      begin
        energy_term <= next_energy;
        pulse_freq_outputs <= next_pulse;
      end
    end
  end

  // Reverse power detection from the selected power source.
  always_comb
  begin
    for (int p = 0; p < 3; p++)
    begin
      act_rev[p] = active_reverse_source_sel ? active_fund[p][PW-1]
                                             : active_total[p][PW-1];
      react_rev[p] = reactive_reverse_source_sel ? reactive_fund[p][PW-1]
                                                 : reactive_total[p][PW-1];
    end
    event_set = '0;
    if (sample_valid)
    begin
      event_set[mmac_pkg::ACT_REV_LSB +: 3] = act_rev;
      event_set[mmac_pkg::REACT_REV_LSB +: 3] = react_rev;
    end
    event_clr = '0;
    if (wr_fire && (32'(aw_addr) == mmac_pkg::EVENT_ADDR))
    begin
      for (int b = 0; b < 4; b++)
      begin
        event_clr[b*8 +: 8] = w_strb[b] ? w_data[b*8 +: 8] : 8'h00;
      end
    end
  end

  // A new event in the clearing cycle stays set.
  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      event_word_zero <= mmac_pkg::EVENT_RESET;
    end
    else if (clk_en)
    begin
      event_word_zero <= ((event_word_zero & ~event_clr) | event_set) & mmac_pkg::EVENT_USED;
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq <= 1'b0;
    end
    else if (clk_en)
    begin
      irq <= |(event_word_zero & event_mask);
    end
  end

  // Largest magnitude among the included phases only.
  always_comb
  begin
    logic [PW-1:0] mag;
    mag = '0;
    next_volt_peak = '0;
    next_curr_peak = '0;
    next_volt_phase = '0;
    next_curr_phase = '0;
    for (int p = 0; p < 3; p++)
    begin
      mag = volt_sample[p][PW-1] ? PW'(-volt_sample[p]) : volt_sample[p];
      if (peak_phase_include[p] && (mag > next_volt_peak))
      begin
        next_volt_peak = mag;
        next_volt_phase = 3'(1 << p);
      end
      mag = curr_sample[p][PW-1] ? PW'(-curr_sample[p]) : curr_sample[p];
      if (peak_phase_include[p] && (mag > next_curr_peak))
      begin
        next_curr_peak = mag;
        next_curr_phase = 3'(1 << p);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      volt_peak <= '0;
      curr_peak <= '0;
      volt_peak_phase <= '0;
      curr_peak_phase <= '0;
    end
    else if (clk_en && sample_valid)
    begin
      volt_peak <= next_volt_peak;
      curr_peak <= next_curr_peak;
      volt_peak_phase <= next_volt_phase;
      curr_peak_phase <= next_curr_phase;
    end
  end

endmodule // mmac_config

/* testbench/mmac_config_monitor.sv */
module mmac_config_monitor #(
  parameter int PW = 24,
  parameter int AW = 20
) (
  // Clock, reset and enable.
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic clk_en,
  // Register bus.
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [AW-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0] s_axi_rresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Samples and results.
  input wire logic sample_valid,
  input wire logic term_valid,
  input wire logic [3:0][2:0][PW:0] energy_term,
  input wire logic [3:0][2:0][PW:0] pulse_freq_outputs,
  input wire logic [2:0] volt_peak_phase
);
  localparam logic [AW-1:0] MA = mmac_pkg::MEAS_MODE_ADDR[AW-1:0];
  localparam logic [AW-1:0] CA = mmac_pkg::ACC_MODE_ADDR[AW-1:0];
  logic ar_ok;
  logic mapped;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  assign ar_ok = s_axi_arvalid && s_axi_arready;
  assign mapped = s_axi_araddr inside {MA, CA, mmac_pkg::EVENT_ADDR[AW-1:0],
    mmac_pkg::EVENT_MASK_ADDR[AW-1:0], mmac_pkg::PEAK_ADDR[AW-1:0]};
  chk_term_follows: assert property ((sample_valid && clk_en) |=> term_valid)
    else $error("term_valid missing after a sample.");
  chk_term_single: assert property (!(sample_valid && clk_en) |=> !term_valid)
    else $error("term_valid without a sample.");
  chk_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
    s_axi_bvalid && $stable(s_axi_bresp)) else $error("Write answer dropped early.");
  chk_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
    s_axi_rvalid && $stable(s_axi_rdata)) else $error("Read answer dropped early.");
  chk_ar_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("Read address taken while a read answer stands.");
  chk_unmapped_read: assert property (ar_ok && !mapped |=>
    s_axi_rresp == mmac_pkg::RESP_SLVERR && s_axi_rdata == '0)
    else $error("Unmapped read not refused.");
  chk_meas_reserved: assert property (ar_ok && s_axi_araddr == MA |=>
    s_axi_rdata[31:5] == '0) else $error("Reserved measurement bits read nonzero.");
  chk_acc_reserved: assert property (ar_ok && s_axi_araddr == CA |=>
    s_axi_rdata[31:4] == '0) else $error("Reserved accumulation bits read nonzero.");
  chk_act_energy: assert property (term_valid |->
    energy_term[0][0] == pulse_freq_outputs[0][0] ||
    (energy_term[0][0] == '0 && pulse_freq_outputs[0][0][PW]))
    else $error("Active energy term inconsistent with pulse term.");
  chk_react_same: assert property (term_valid |->
    energy_term[2][1] == pulse_freq_outputs[2][1])
    else $error("Reactive energy and pulse terms differ.");
  chk_peak_onehot: assert property (term_valid |-> $onehot0(volt_peak_phase))
    else $error("Peak phase not one-hot.");
endmodule // mmac_config_monitor

bind mmac_config mmac_config_monitor #(.PW(PW), .AW(AW)) mmac_config_monitor_i (
  .ref_clk(ref_clk), .nrst(nrst), .clk_en(clk_en), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .sample_valid(sample_valid), .term_valid(term_valid), .energy_term(energy_term),
  .pulse_freq_outputs(pulse_freq_outputs), .volt_peak_phase(volt_peak_phase));

/* testbench/test_metering_mode_accum_config.sv */
module test_metering_mode_accum_config;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int PW = 8;
  localparam int AW = 20;
  localparam logic [31:0] MA = mmac_pkg::MEAS_MODE_ADDR;
  localparam logic [31:0] CA = mmac_pkg::ACC_MODE_ADDR;
  localparam logic [31:0] EA = mmac_pkg::EVENT_ADDR;
  localparam logic [31:0] KA = mmac_pkg::EVENT_MASK_ADDR;
  localparam logic [1:0] OK = mmac_pkg::RESP_OKAY;
  localparam logic [1:0] SE = mmac_pkg::RESP_SLVERR;
  logic ref_clk, nrst, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, sv, tv, irq, ce;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0] bresp, rresp;
  logic [3:0][2:0][PW-1:0] pw;
  logic [2:0][PW-1:0] vs, cs;
  logic [3:0][2:0][PW:0] et, pf;
  logic [PW-1:0] vpk, cpk;
  logic [2:0] vph, cph;
  int fail_count, num_checks;

  mmac_config #(.PW(PW), .AW(AW)) mmac_config_i (
    .ref_clk(ref_clk), .nrst(nrst), .clk_en(ce),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .sample_valid(sv), .active_total(pw[0]), .active_fund(pw[1]),
    .reactive_total(pw[2]), .reactive_fund(pw[3]), .volt_sample(vs), .curr_sample(cs),
    .term_valid(tv), .energy_term(et), .pulse_freq_outputs(pf),
    .volt_peak(vpk), .curr_peak(cpk), .volt_peak_phase(vph), .curr_peak_phase(cph),
    .irq(irq));

  initial
  begin
    ref_clk = 0;
    forever #20 ref_clk = ~ref_clk;
  end

  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask

  // Write with both channels offered together; readies are looked at mid-cycle.
  task wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] er);
    logic ad, wd;
    ad = 0;
    wd = 0;
    @(posedge ref_clk);
    awaddr <= a[AW-1:0];
    wdata <= d;
    {awvalid, wvalid, bready} <= 3'b111;
    while (!(ad && wd))
    begin
      @(negedge ref_clk);
      ad = ad || (awvalid && awready);
      wd = wd || (wvalid && wready);
      @(posedge ref_clk);
      if (ad) awvalid <= 0;
      if (wd) wvalid <= 0;
    end
    do @(negedge ref_clk); while (!bvalid);
    chk("bresp", 32'(er), 32'(bresp));
    @(posedge ref_clk);
    bready <= 0;
  endtask

  task rd(input logic [31:0] a, input logic [1:0] er, input logic [31:0] ed);
    @(posedge ref_clk);
    araddr <= a[AW-1:0];
    {arvalid, rready} <= 2'b11;
    do @(negedge ref_clk); while (!arready);
    @(posedge ref_clk);
    arvalid <= 0;
    do @(negedge ref_clk); while (!rvalid);
    chk("rresp", 32'(er), 32'(rresp));
    chk("rdata", ed, rdata);
    @(posedge ref_clk);
    rready <= 0;
  endtask

  task sample();
    @(posedge ref_clk);
    sv <= 1;
    @(posedge ref_clk);
    sv <= 0;
    #1;
    chk("term_valid", 32'h0000_0001, 32'(tv));
  endtask

  task irq_is(input logic e);
    @(negedge ref_clk);
    chk("irq", 32'(e), 32'(irq));
  endtask

  // Expected conditioned term; kinds 0 and 1 are active, 2 and 3 reactive.
  function automatic logic [PW:0] cnd(input int k, input logic [1:0] c,
    input logic [PW-1:0] v, input logic ng, input bit en);
    logic signed [PW:0] x;
    x = {v[PW-1], v};
    if (k < 2 && c == 2'h1 && en && x < 0) return '0;
    if (c == 2'h3) return x < 0 ? -x : x;
    if (k > 1 && c == 2'h2 && ng) return -x;
    return x;
  endfunction

  task t_reset();
    rd(MA, OK, 32'h0000_001c);
    rd(CA, OK, 32'h0000_0000);
    rd(KA, OK, 32'h0000_0000);
    rd(32'h0003_9c08, SE, 32'h0000_0000);
    wr(32'h0003_9c08, 32'hffff_ffff, SE);
    wr(MA, 32'hffff_ffff, OK);
    rd(MA, OK, 32'h0000_001f);
    wr(CA, 32'hffff_ffff, OK);
    rd(CA, OK, 32'h0000_000f);
    $display("TEST reset and reserved bits done");
  endtask

  task t_accum();
    logic [1:0] c;
    logic [PW:0] e;
    for (int i = 0; i < 4; i++)
    begin
      c = 2'(i);
      wr(CA, 32'({c, c}), OK);
      sample();
      for (int k = 0; k < 4; k++)
        for (int p = 0; p < 3; p++)
        begin
          e = cnd(k, c, pw[k][p], pw[k % 2][p][PW-1], 1);
          chk("energy", 32'(e), 32'(et[k][p]));
          e = cnd(k, c, pw[k][p], pw[k % 2][p][PW-1], 0);
          chk("pulse", 32'(e), 32'(pf[k][p]));
        end
    end
    $display("TEST accumulation codes done");
  endtask

  task t_events();
    wr(EA, 32'h0000_1dc0, OK);
    wr(MA, 32'h0000_001c, OK);
    sample();
    rd(EA, OK, 32'h0000_0940);
    irq_is(0);
    wr(KA, 32'h0000_1dc0, OK);
    irq_is(1);
    wr(EA, 32'h0000_1dc0, OK);
    wr(MA, 32'h0000_001f, OK);
    sample();
    rd(EA, OK, 32'h0000_1480);
    wr(EA, 32'h0000_1480, OK);
    rd(EA, OK, 32'h0000_0000);
    irq_is(0);
    $display("TEST reverse flags and irq done");
  endtask

  task pk(input logic [31:0] m, input logic [PW-1:0] ev, input logic [2:0] pv,
    input logic [PW-1:0] ec, input logic [2:0] pc);
    wr(MA, m, OK);
    sample();
    chk("volt_peak", 32'(ev), 32'(vpk));
    chk("volt_phase", 32'(pv), 32'(vph));
    chk("curr_peak", 32'(ec), 32'(cpk));
    chk("curr_phase", 32'(pc), 32'(cph));
  endtask

  task t_peak();
    pk(32'h0000_001c, 8'h14, 3'b010, 8'h1e, 3'b001);
    pk(32'h0000_00f8, 8'h14, 3'b010, 8'h06, 3'b100);
    pk(32'h0000_0000, 8'h00, 3'b000, 8'h00, 3'b000);
    $display("TEST peak include bits done");
  endtask

  // A sample offered while the enable is low must leave term_valid and the event word untouched, with awready low.
  task t_freeze();
    @(posedge ref_clk);
    ce <= 0;
    sv <= 1;
    @(posedge ref_clk);
    sv <= 0;
    #1;
    chk("term_valid", 32'h0000_0000, 32'(tv));
    chk("awready", 32'h0000_0000, 32'(awready));
    @(posedge ref_clk);
    ce <= 1;
    rd(EA, OK, 32'h0000_0000);
    $display("TEST clock enable freeze done");
  endtask

  task close_out();
    $display("Checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  initial
  begin
    nrst = 0;
    {sv, awvalid, wvalid, bready, arvalid, rready} = '0;
    ce = 1;
    {awaddr, araddr, wdata} = '0;
    fail_count = 0;
    num_checks = 0;
    pw = {24'hf706ff, 24'h04fe07, 24'h00f902, 24'h8003fb};
    vs = {8'h0f, 8'hec, 8'h0a};
    cs = {8'h06, 8'h05, 8'he2};
    repeat (5) @(posedge ref_clk);
    nrst <= 1;
    t_reset();
    t_accum();
    t_events();
    t_freeze();
    t_peak();
    close_out();
  end

  // Far longer than the tests need; only a hang gets here.
  initial
  begin
    #400000;
    fail_count++;
    close_out();
  end
endmodule // test_metering_mode_accum_config
